/* File: hw/aalc_pkg.sv */
// constants, register map and state types of the audio level control
package aalc_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CEIL = 4'h4;
   localparam logic [3:0] OFS_STAT = 4'h8;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // control word field positions
   localparam int B_EN = 0;
   localparam int B_PATH = 1;
   localparam int B_DFDIS = 2;
   localparam int B_FRDIS = 3;
   localparam int B_FRSLOW = 4;
   localparam int B_CORNER = 5;
   localparam int B_THR = 7;
   localparam int B_WAIT = 10;
   localparam int B_RSTEP = 12;
   localparam int B_FSPD = 15;
   localparam int CTRL_W = 17;
   localparam logic [16:0] CTRL_RESET = 17'h00040;
   localparam logic [7:0] CEIL_RESET = 8'hE1;
   // ---------------------------------------------------------------
   // gain scale: one unit is 0.00106 dB, zero means mute
   // ---------------------------------------------------------------
   localparam logic [16:0] G_ZERO = 17'h10A40;
   localparam logic [16:0] G_OCT = 17'h01630;
   localparam logic [31:0] MANT_K = 32'h00000B89;
   localparam logic [7:0] CEIL_ZCODE = 8'h91;
   localparam logic [7:0] CEIL_MIN = 8'h05;
   localparam logic [16:0] CEIL_STEP = 17'h00162;
   localparam logic [16:0] RB_STEP = 17'h002C4;
   localparam logic [7:0] RB_ZCODE = 8'hA0;
   localparam logic [7:0] RB_FLOOR = 8'h10;
   localparam int RB_TOP_IDX = 48;
   localparam int RB_BOT_IDX = -71;
   // limiter attenuation steps
   localparam logic [16:0] ATT_CLIP = 17'h00168;
   localparam logic [16:0] ATT_MID = 17'h00040;
   localparam logic [16:0] ATT_LOW = 17'h00018;
   // ---------------------------------------------------------------
   // levels, fraction of full scale times 65536
   // ---------------------------------------------------------------
   localparam logic [19:0] LVL_CLIP = 20'h1101C;
   localparam logic [19:0] LVL_MID = 20'h0DFFF;
   localparam logic [19:0] LVL_SLOW = 20'h0404E;
   localparam logic [7:0][19:0] DET_LVL = {
      20'h06037, 20'h06037, 20'h0804E, 20'h0804E,
      20'h09FAD, 20'h09FAD, 20'h0BFF9, 20'h0BFF9};
   localparam logic [7:0][19:0] RST_LVL = {
      20'h05007, 20'h0404E, 20'h06FC0, 20'h06037,
      20'h08FF6, 20'h0804E, 20'h0AF15, 20'h09FAD};
   // detection high-pass pole per corner code, Q15
   localparam logic [15:0] HPF_K0 = 16'h794F;
   localparam logic [15:0] HPF_K1 = 16'h7B05;
   localparam logic [15:0] HPF_K2 = 16'h7D85;
   // ---------------------------------------------------------------
   // timing in sample periods
   // ---------------------------------------------------------------
   localparam logic [3:0] LIMIT_STEPS = 4'hF;
   localparam logic [10:0] WAIT_BASE = 11'h080;
   localparam logic [3:0] FR_TICK_FAST = 4'h3;
   localparam logic [3:0] FR_TICK_SLOW = 4'hF;
   // saturation bounds
   localparam logic signed [26:0] X_MAX = 27'sh3FFFFFF;
   localparam logic signed [26:0] X_MIN = 27'sh4000000;
   localparam logic signed [23:0] S_MAX = 24'sh7FFFFF;
   localparam logic signed [23:0] S_MIN = 24'sh800000;

   typedef enum logic [1:0] {
      S_OFF, S_LIMIT, S_WAIT, S_RECOVER
   } aalc_state_type;

   typedef struct packed {
      logic awrdy;
      logic wrdy;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [3:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [16:0] ctrl;
      logic [7:0] ceil;
      aalc_state_type state;
      logic [16:0] gain;
      logic [16:0] top;
      logic [3:0] lim_cnt;
      logic [10:0] wait_cnt;
      logic [6:0] div_cnt;
      logic [3:0] fr_cnt;
      logic impulse;
      logic meas_v;
      logic signed [26:0] xl;
      logic signed [26:0] yl;
      logic signed [26:0] xr;
      logic signed [26:0] yr;
      logic out_v;
      logic [23:0] rec_l;
      logic [23:0] rec_r;
      logic [23:0] play_l;
      logic [23:0] play_r;
   } aalc_regs_type;
endpackage : aalc_pkg

/* File: hw/aalc_top.sv */
// stereo automatic level control with its register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Functional notes
// RULE_01: path bit picks record/playback; enable bit gates.
// RULE_02: threshold on filtered level; clip detect at +0.53dBFS.
// RULE_03: corner code picks filter pole per rate.
// RULE_04: filter disable bit uses unfiltered level.
// RULE_05: either channel over threshold lowers shared gain.
// RULE_06: one limiter event applies sixteen steps.
// RULE_07: limiter retriggers while enable stays set.
// RULE_08: threshold code selects detect/reset level pair.
// RULE_09: step size follows the measured output level.
// RULE_10: quiet waiting period then recovery starts.
// RULE_11: waiting period 128 to 1024 samples.
// RULE_12: recovery raises gain up to ceiling only.
// RULE_13: recovery step code sets size and interval.
// RULE_14: ceiling code maps 0.375dB steps, low codes mute.
// RULE_15: loud peaks halve the recovery rate.
// RULE_16: reset window clears timer; below restarts it.
// RULE_17: fast recovery after impulse unless disabled.
// RULE_18: fast speed code sets fast gain step.
// RULE_19: fast mode lowers ceiling every 4/16 samples.
// RULE_20: status reports live gain in 0.75dB codes.
// RULE_21: software stops the block before retuning.
// RULE_22: all timing advances on the sample strobe.
// RULE_23: both channels get the same gain.
module aalc_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register bus, axi4-lite
   input wire logic [aalc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [aalc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // audio samples in, one strobe per sample period
   input wire logic sample_valid,
   input wire logic signed [23:0] rec_in_l,
   input wire logic signed [23:0] rec_in_r,
   input wire logic signed [23:0] play_in_l,
   input wire logic signed [23:0] play_in_r,
   // audio samples out
   output logic out_valid,
   output logic [23:0] rec_out_l,
   output logic [23:0] rec_out_r,
   output logic [23:0] play_out_l,
   output logic [23:0] play_out_r
);
   import aalc_pkg::*;

   // ---------------------------------------------------------------
   // arithmetic helpers
   // ---------------------------------------------------------------
   function automatic logic signed [26:0] clamp27(
      input logic signed [55:0] p);
      if (p > 56'(X_MAX)) return X_MAX;
      if (p < 56'(X_MIN)) return X_MIN;
      return 27'(p);
   endfunction : clamp27

   function automatic logic [23:0] sat24(input logic signed [26:0] x);
      if (x > 27'(S_MAX)) return S_MAX;
      if (x < 27'(S_MIN)) return S_MIN;
      return 24'(x);
   endfunction : sat24

   // log gain to linear: shift per doubling, linear mantissa between
   function automatic logic signed [26:0] amp(
      input logic signed [23:0] s, input logic [16:0] g);
      logic [4:0] q;
      logic [16:0] r;
      logic [13:0] m;
      logic signed [55:0] p;
      q = 5'(g / G_OCT);
      r = g - 17'(q) * G_OCT;
      m = 14'(32'h1000 + ((32'(r) * MANT_K) >> 12));
      p = (56'(s) * 56'(signed'({1'b0, m}))) <<< q;
      if (g == '0) return '0;
      return clamp27(p >>> 24);
   endfunction : amp

   // first-order zero-pole high-pass
   function automatic logic signed [26:0] hpf(
      input logic signed [26:0] x, input logic signed [26:0] xp,
      input logic signed [26:0] yp, input logic [15:0] k);
      logic signed [55:0] t;
      t = (56'(x) - 56'(xp) + 56'(yp)) * 56'(signed'({1'b0, k}));
      return clamp27(t >>> 15);
   endfunction : hpf

   function automatic logic [19:0] mag(input logic signed [26:0] v);
      logic [26:0] a;
      a = v[26] ? 27'(-v) : 27'(v);
      return 20'(a >> 7);
   endfunction : mag

   function automatic logic [19:0] max20(input logic [19:0] a,
      input logic [19:0] b);
      return (a > b) ? a : b;
   endfunction : max20

   function automatic logic [16:0] ceil_gain(input logic [7:0] c);
      if (c < CEIL_MIN) return '0;                            // RULE_14
      return 17'(int'(G_ZERO) + (int'(c) - int'(CEIL_ZCODE))
         * int'(CEIL_STEP));
   endfunction : ceil_gain

   function automatic logic [7:0] gain_code(input logic [16:0] g);
      int d;
      int idx;
      d = int'(g) - int'(G_ZERO);
      if (d >= 0) idx = d / int'(RB_STEP);
      else idx = -((-d + int'(RB_STEP) - 1) / int'(RB_STEP));
      if (g == '0) return 8'h00;
      if (idx >= RB_TOP_IDX) return 8'hFF;
      if (idx < RB_BOT_IDX) return RB_FLOOR;
      return 8'(int'(RB_ZCODE) + 2 * idx);
   endfunction : gain_code

   // saturating raise toward a ceiling, never past it; a gain already at or above it is kept
   function automatic logic [16:0] raise(input logic [16:0] g,
      input logic [16:0] s, input logic [16:0] top);
      if (g >= top) return g;
      if (top - g < s) return top;
      return g + s;
   endfunction : raise

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = d[8*i +: 8];
      end
      return r;
   endfunction : merge

   // ---------------------------------------------------------------
   // state and configuration decode
   // ---------------------------------------------------------------
   aalc_regs_type st;
   aalc_regs_type nx;
   localparam aalc_regs_type ST_RESET = '{awrdy: 1'b1, wrdy: 1'b1,
      arrdy: 1'b1, ctrl: CTRL_RESET, ceil: CEIL_RESET,
      state: S_OFF, default: '0};

   logic en, path, dfdis, frdis, frslow;
   logic [1:0] corner, wsel, fspd;
   logic [2:0] thr, rstep;
   assign en = st.ctrl[B_EN];
   assign path = st.ctrl[B_PATH];
   assign dfdis = st.ctrl[B_DFDIS];
   assign frdis = st.ctrl[B_FRDIS];
   assign frslow = st.ctrl[B_FRSLOW];
   assign corner = st.ctrl[B_CORNER +: 2];
   assign thr = st.ctrl[B_THR +: 3];
   assign wsel = st.ctrl[B_WAIT +: 2];
   assign rstep = st.ctrl[B_RSTEP +: 3];
   assign fspd = st.ctrl[B_FSPD +: 2];

   // level detection one cycle after each sample
   logic [19:0] lv_raw, lv_det;
   logic above, inwin, clip, slow;
   logic [10:0] wlen;
   logic [15:0] hk;
   logic [16:0] att, rstep_sz, fstep;
   logic [6:0] rint;
   assign lv_raw = max20(mag(st.xl), mag(st.xr));
   assign lv_det = dfdis ? lv_raw :                          // RULE_04
      max20(mag(st.yl), mag(st.yr));                          // RULE_02
   assign clip = lv_raw >= LVL_CLIP;                          // RULE_02
   assign above = lv_det >= DET_LVL[thr];                     // RULE_08
   assign inwin = !above && lv_det >= RST_LVL[thr];           // RULE_16
   assign slow = lv_raw > LVL_SLOW;                           // RULE_15
   assign wlen = WAIT_BASE << wsel;                           // RULE_11
   // code 11 has no corner of its own; it falls back to the top range
   assign hk = (corner == 2'h0) ? HPF_K0 :                    // RULE_03
      (corner == 2'h1) ? HPF_K1 : HPF_K2;

   // step sizes and intervals from the configuration and the measured level
   always_comb begin
      if (clip) att = ATT_CLIP;                               // RULE_09
      else if (lv_det >= LVL_MID) att = ATT_MID;
      else att = ATT_LOW;
      case (rstep)                                            // RULE_13
         3'h0: rstep_sz = 17'h00004;
         3'h1: rstep_sz = 17'h00002;
         default: rstep_sz = 17'h00001;
      endcase
      rint = (rstep < 3'h3) ? 7'h01 : 7'(7'h01 << (rstep - 3'h2));
      if (slow) rint = 7'(rint << 1);                         // RULE_15
      case (fspd)                                             // RULE_18
         2'h0: fstep = 17'h00003;
         2'h1: fstep = 17'h00004;
         2'h2: fstep = 17'h00006;
         default: fstep = 17'h0000C;
      endcase
   end

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   // bus slave, sample path and level control all fill one copy
   always_comb begin
      logic signed [23:0] il, ir;
      logic signed [26:0] gl, gr;
      il = path ? rec_in_l : play_in_l;                       // RULE_01
      ir = path ? rec_in_r : play_in_r;
      gl = amp(il, st.gain);                                  // RULE_23
      gr = amp(ir, st.gain);
      nx = st;
      // write channel: address and data land in either order
      if (s_axi_awvalid && st.awrdy) begin
         nx.awrdy = 1'b0;
         nx.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wrdy) begin
         nx.wrdy = 1'b0;
         nx.wdata = s_axi_wdata;
         nx.wstrb = s_axi_wstrb;
      end
      if (!st.awrdy && !st.wrdy && !st.bvalid) begin
         nx.bvalid = 1'b1;
         nx.bresp = RESP_OK;
         case (st.waddr)
            OFS_CTRL: nx.ctrl = CTRL_W'(merge(32'(st.ctrl),
               st.wdata, st.wstrb));
            OFS_CEIL: nx.ceil = 8'(merge(32'(st.ceil),
               st.wdata, st.wstrb));
            OFS_STAT: nx.bresp = RESP_OK;
            default: nx.bresp = RESP_SLVERR;
         endcase
      end
      if (st.bvalid && s_axi_bready) begin
         nx.bvalid = 1'b0;
         nx.awrdy = 1'b1;
         nx.wrdy = 1'b1;
      end
      // read channel answers one cycle after the address
      if (s_axi_arvalid && st.arrdy) begin
         nx.arrdy = 1'b0;
         nx.rvalid = 1'b1;
         nx.rresp = RESP_OK;
         case (s_axi_araddr)
            OFS_CTRL: nx.rdata = 32'(st.ctrl);
            OFS_CEIL: nx.rdata = 32'(st.ceil);
            OFS_STAT: nx.rdata = {22'h0, 2'(st.state),
               gain_code(st.gain)};                           // RULE_20
            default: begin
               nx.rdata = '0;
               nx.rresp = RESP_SLVERR;
            end
         endcase
      end else if (st.rvalid && s_axi_rready) begin
         nx.rvalid = 1'b0;
         nx.arrdy = 1'b1;
      end
      // sample stage: gain the selected pair, pass the other through
      nx.out_v = sample_valid;                                // RULE_22
      nx.meas_v = sample_valid;
      if (sample_valid) begin
         nx.rec_l = path ? sat24(gl) : rec_in_l;
         nx.rec_r = path ? sat24(gr) : rec_in_r;
         nx.play_l = path ? play_in_l : sat24(gl);
         nx.play_r = path ? play_in_r : sat24(gr);
         nx.xl = gl;
         nx.xr = gr;
         nx.yl = hpf(gl, st.xl, st.yl, hk);                   // RULE_02
         nx.yr = hpf(gr, st.xr, st.yr, hk);
      end
      // level control, one decision per measured sample
      if (!en) begin                                          // RULE_01
         nx.state = S_OFF;
         nx.gain = ceil_gain(st.ceil);
         nx.top = ceil_gain(st.ceil);
         nx.impulse = 1'b0;
      end else if (st.meas_v) begin                           // RULE_22
         case (st.state)
            S_LIMIT: begin
               nx.gain = (st.gain > att) ? st.gain - att : '0; // RULE_05
               if (clip && !frdis) nx.impulse = 1'b1;
               nx.lim_cnt = st.lim_cnt + 4'h1;
               if (st.lim_cnt == LIMIT_STEPS) begin           // RULE_06
                  nx.state = S_WAIT;
                  nx.wait_cnt = '0;
               end
            end
            S_WAIT: begin
               if (inwin) nx.wait_cnt = '0;                   // RULE_16
               else if (st.wait_cnt == wlen - 11'h1) begin    // RULE_10
                  nx.state = S_RECOVER;
                  nx.div_cnt = '0;
               end else nx.wait_cnt = st.wait_cnt + 11'h1;
            end
            S_RECOVER: begin
               if (inwin) begin                               // RULE_16
                  nx.state = S_WAIT;
                  nx.wait_cnt = '0;
               end else if (st.impulse) begin                 // RULE_17
                  nx.gain = raise(st.gain, fstep, st.top);
                  nx.fr_cnt = st.fr_cnt + 4'h1;
                  if (st.fr_cnt == (frslow ? FR_TICK_SLOW
                     : FR_TICK_FAST)) begin                    // RULE_19
                     nx.fr_cnt = '0;
                     if (st.top != '0) nx.top = st.top - 17'h1;
                  end
                  // fast mode ends on reaching the lowered ceiling
                  if (st.gain >= st.top) begin
                     nx.impulse = 1'b0;
                     nx.top = ceil_gain(st.ceil);
                  end
               end else if (st.div_cnt >= rint - 7'h1) begin  // RULE_13
                  nx.div_cnt = '0;
                  nx.gain = raise(st.gain, rstep_sz, st.top); // RULE_12
               end else nx.div_cnt = st.div_cnt + 7'h1;
            end
            default: begin
               nx.state = S_RECOVER;
               nx.div_cnt = '0;
            end
         endcase
         // a new crossing starts an event and takes its first step
         if (above && st.state != S_LIMIT) begin              // RULE_07
            nx.state = S_LIMIT;
            nx.lim_cnt = 4'h1;
            nx.gain = (st.gain > att) ? st.gain - att : '0;   // RULE_05
            nx.impulse = st.impulse | (clip & !frdis);        // RULE_17
         end
      end
   end

   // one register for the whole state
   always_ff @(posedge core_clk) begin
      if (!rst_n) st <= ST_RESET;
      else st <= nx;
   end

   // ---------------------------------------------------------------
   // outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign s_axi_awready = st.awrdy;
   assign s_axi_wready = st.wrdy;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arrdy;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign out_valid = st.out_v;
   assign rec_out_l = st.rec_l;
   assign rec_out_r = st.rec_r;
   assign play_out_l = st.play_l;
   assign play_out_r = st.play_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_lim_count;
      en && st.meas_v && st.state == S_LIMIT && st.lim_cnt == 4'hF
         |=> st.state == S_WAIT || st.state == S_OFF;
   endproperty
   a_lim_count: assert property (p_lim_count) // RULE_06
      else $error("limiter event did not end after 16 steps");

   property p_lim_dec;
      en && st.meas_v && above && st.state != S_LIMIT && st.gain > att
         |=> st.state == S_LIMIT && st.gain == $past(st.gain) - $past(att);
   endproperty
   a_lim_dec: assert property (p_lim_dec) // RULE_05
      else $error("threshold crossing did not lower gain");

   property p_ceiling;
      en && st.state == S_RECOVER && st.gain >= st.top && !above
         |=> st.gain <= $past(st.gain);
   endproperty
   a_ceiling: assert property (p_ceiling) // RULE_12
      else $error("recovery raised gain above ceiling");

   // a ceiling write lands one cycle before the gain follows it
   property p_off_gain;
      !en |=> st.gain == ceil_gain($past(st.ceil));
   endproperty
   a_off_gain: assert property (p_off_gain) // RULE_01
      else $error("disabled block does not hold ceiling gain");

   property p_wait_reset;
      en && st.meas_v && st.state == S_WAIT && inwin
         |=> st.wait_cnt == 11'h0 && st.state == S_WAIT;
   endproperty
   a_wait_reset: assert property (p_wait_reset) // RULE_16
      else $error("waiting timer not cleared in reset window");

   property p_wait_done;
      en && st.meas_v && st.state == S_WAIT && !above && !inwin
         && st.wait_cnt == wlen - 11'h1 |=> st.state == S_RECOVER;
   endproperty
   a_wait_done: assert property (p_wait_done) // RULE_10
      else $error("recovery did not start after waiting period");

   property p_retrig;
      en && st.meas_v && above && st.state == S_WAIT
         ##1 en |-> st.state == S_LIMIT;
   endproperty
   a_retrig: assert property (p_retrig) // RULE_07
      else $error("limiter not retriggered");

   property p_strobe;
      sample_valid |=> out_valid ##1 !out_valid || $past(sample_valid);
   endproperty
   a_strobe: assert property (p_strobe) // RULE_22
      else $error("output strobe does not follow sample strobe");

   property p_stereo;
      sample_valid && path && rec_in_l == rec_in_r
         |=> rec_out_l == rec_out_r;
   endproperty
   a_stereo: assert property (p_stereo) // RULE_23
      else $error("left and right channels got different gain");

   property p_no_fast;
      frdis && $past(frdis) && st.state != S_RECOVER
         |=> !st.impulse || $past(st.impulse);
   endproperty
   a_no_fast: assert property (p_no_fast) // RULE_17
      else $error("fast recovery armed while disabled");
endmodule : aalc_top

/* File: test/audio_auto_level_control_tb.sv */
// self-checking bench for the audio level control
`timescale 1ns/1ps
module audio_auto_level_control_tb;
   import aalc_pkg::*;
   typedef struct packed {
      logic [3:0] a;
      logic [31:0] d;
      logic [31:0] x;
      logic [1:0] r;
   } aalc_row_type;
   logic core_clk = 0;
   logic rst_n = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, sample_valid = 0;
   logic [31:0] s_axi_wdata = 0;
   logic signed [23:0] rec_in_l = 0, rec_in_r = 0;
   logic signed [23:0] play_in_l = 0, play_in_r = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, out_valid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [23:0] rec_out_l, rec_out_r, play_out_l, play_out_r;
   int err_total = 0;
   int comparisons = 0;
   logic [31:0] v;
   logic [1:0] r;
   // write, read back; upper control bits and unmapped places read 0
   aalc_row_type rows [4] = '{
      '{OFS_CEIL, 32'h91, 32'h91, RESP_OK},
      '{OFS_CTRL, 32'hFFFFFFFF, 32'h1FFFF, RESP_OK},
      '{4'hC, 32'h55, 32'h0, RESP_SLVERR},
      '{OFS_CTRL, 32'h0, 32'h0, RESP_OK}};

   aalc_top DUT (.*);

   // 25 MHz clock
   initial forever #20 core_clk = ~core_clk;

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : ck

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid && n < 40);
      r = s_axi_bresp;
      s_axi_bready <= 0;
      if (!s_axi_bvalid) begin
         err_total++;
         $display("unexpected at %0t: write answer timed out", $time);
         tally_and_finish();
      end
   endtask : wr

   task automatic rd(input logic [3:0] a);
      int n;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid && n < 40);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
      if (!s_axi_rvalid) begin
         err_total++;
         $display("unexpected at %0t: read answer timed out", $time);
         tally_and_finish();
      end
   endtask : rd

   // samples three cycles apart so each level decision has its cycle
   task automatic smp(input logic [23:0] x, input int n);
      repeat (n) begin
         @(posedge core_clk);
         sample_valid <= 1;
         rec_in_l <= x;
         rec_in_r <= x;
         play_in_l <= 24'h123456;
         play_in_r <= x;
         @(posedge core_clk);
         sample_valid <= 0;
         #1 ck({31'h0, out_valid}, 32'h1);
         @(posedge core_clk);
         #1 ck({31'h0, out_valid}, 32'h0);
      end
   endtask : smp

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         ck({30'h0, r}, {30'h0, rows[i].r});
         rd(rows[i].a);
         ck(v, rows[i].x);
         ck({30'h0, r}, {30'h0, rows[i].r});
      end
      // second reset in mid-run restores defaults
      rst_n <= 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1;
      rd(OFS_CTRL);
      ck(v, 32'h40);
      rd(OFS_CEIL);
      ck(v, 32'hE1);
      // disabled: unselected path passes, gain follows the ceiling
      wr(OFS_CEIL, 32'h91);
      wr(OFS_CTRL, 32'h2);
      smp(24'h400000, 2);
      ck({8'h0, play_out_l}, 32'h123456);
      ck({8'h0, rec_out_l}, 32'h400000);
      ck({8'h0, rec_out_r}, 32'h400000);
      rd(OFS_STAT);
      ck(v & 32'h3FF, 32'hA0);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_CEIL, 32'h0);
      smp(24'h400000, 2);
      ck({8'h0, rec_out_l}, 32'h400000);
      ck({8'h0, play_out_l}, 32'h0);
      ck({8'h0, play_out_r}, 32'h0);
      rd(OFS_STAT);
      ck(v & 32'h3FF, 32'h0);
      // one loud sample, then silence through limit, wait, recovery
      wr(OFS_CEIL, 32'h91);
      wr(OFS_CTRL, 32'h7);
      smp(24'h7FFFFF, 1);
      smp(24'h0, 7);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h100);
      smp(24'h0, 12);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h200);
      ck({31'h0, v[7:0] < 8'hA0}, 32'h1);
      smp(24'h0, 100);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h200);
      smp(24'h0, 40);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h300);
      smp(24'h7FFFFF, 1);
      smp(24'h0, 3);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h100);
      // finish that event, then cross again from the waiting state
      smp(24'h0, 13);
      smp(24'h7FFFFF, 1);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h100);
      // a sample inside the reset window keeps the block waiting
      smp(24'h0, 15);
      smp(24'h600000, 1);
      rd(OFS_STAT);
      ck(v & 32'h300, 32'h200);
      tally_and_finish();
   end
endmodule : audio_auto_level_control_tb
